// *** hsq_axis_model.sv ***
// axis, switch and encoder model driven by the homing sequencer
module hsq_axis_model #(
  parameter int HS_LO = 104,  // first count with home switch on
  parameter int HS_HI = 152,  // last count with home switch on
  parameter int NL_AT = 10,   // negative limit on at or below
  parameter int PL_AT = 300,  // positive limit on at or above
  parameter int IDX_P = 16,   // counts between index pulses
  parameter int COAST = 3     // cycles of travel after run drops
) (
  input  wire logic        clk_sys_i,                // system clock
  input  wire logic        run_i,                    // move command
  input  wire logic        dir_neg_i,                // 1 = negative
  input  wire logic        load_i,                   // place the axis
  input  wire logic [31:0] load_pos_i,               // placement count
  input  wire logic [1:0]  force_i,                  // {pl, nl} forced on
  output logic             home_switch_o,            // home switch level
  output logic             negative_limit_switch_o,  // negative limit level
  output logic             positive_limit_switch_o,  // positive limit level
  output logic             index_o,                  // index pulse
  output logic      [31:0] position_o,               // encoder count
  output logic             motion_stopped_o          // axis at rest
);
  timeunit 1ns;
  timeprecision 1ps;

  int   pos   = 0;     // axis count
  int   coast = 0;     // remaining decel cycles
  logic dir_q = 1'b0;  // direction held through decel

  // ----------------------------------------------------------------
  // travel: one count a cycle, coasting after the command drops
  // ----------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (run_i) begin
      dir_q <= dir_neg_i;
      coast <= COAST;
    end else if (coast > 0) begin
      coast <= coast - 1;
    end
    if (load_i) begin
      pos <= int'(load_pos_i);
    end else if (run_i || coast > 0) begin
      pos <= (run_i ? dir_neg_i : dir_q) ? pos - 1 : pos + 1;
    end
  end

  // ----------------------------------------------------------------
  // pins seen from the axis position
  // ----------------------------------------------------------------
  assign home_switch_o           = pos >= HS_LO && pos <= HS_HI;
  assign negative_limit_switch_o = pos <= NL_AT || force_i[0];
  assign positive_limit_switch_o = pos >= PL_AT || force_i[1];
  assign index_o                 = (pos % IDX_P) == 0;
  assign position_o              = 32'(pos);
  assign motion_stopped_o        = !run_i && coast == 0;
endmodule

// *** hsq_defs.svh ***
// constants for the homing sequencer of modes eleven to fourteen
// How it works
// - mode 11 active start: forward, back, slow forward
// - mode 12 positive side: negative, back, slow
// - negative limit in 11-14: stop, run positive fast
// - mode 12 reversal: stop at deactivation, slow negative
// - mode 12 active: positive to deactivation, slow negative
// - mode 13 inactive: negative to deactivation, slow positive
// - mode 13 reversal: stop, back off, slow positive
// - mode 13 active: negative to deactivation, slow positive
// - mode 14 inactive: negative, back, slow negative
// - mode 14 reversal: stop at activation, slow negative
// - mode 14 active: negative, back, slow negative
// - first negative limit reverses instead of aborting
// - positive limit or second negative limit aborts
`ifndef HSQ_DEFS_SVH
`define HSQ_DEFS_SVH

// ----------------------------------------------------------------
// mode numbers
// ----------------------------------------------------------------
`define HSQ_MODE_W   5
`define HSQ_MODE_11  5'h0b
`define HSQ_MODE_12  5'h0c
`define HSQ_MODE_13  5'h0d
`define HSQ_MODE_14  5'h0e

// ----------------------------------------------------------------
// default widths and synchroniser depth
// ----------------------------------------------------------------
`define HSQ_POS_W    32
`define HSQ_SPD_W    16
`define HSQ_SYNC_N   2

`endif

// *** hsq_homing.sv ***
// homing sequencer for modes eleven to fourteen
`include "hsq_defs.svh"

module hsq_homing
  import hsq_pkg::*;
#(
  parameter int POS_W = `HSQ_POS_W,  // encoder position width
  parameter int SPD_W = `HSQ_SPD_W   // speed and decel width
) (
  input  wire logic                   clk_sys_i,                // system clock
  input  wire logic                   rst_n_i,                  // sync reset
  input  wire logic                   start_i,                  // start pulse
  input  wire logic [`HSQ_MODE_W-1:0] mode_i,                   // homing mode
  input  wire logic                   home_switch_i,            // pin, high active
  input  wire logic                   negative_limit_switch_i,  // pin, high active
  input  wire logic                   positive_limit_switch_i,  // pin, high active
  input  wire logic                   index_i,                  // encoder index pin
  input  wire logic [POS_W-1:0]       position_i,               // encoder count
  input  wire logic                   motion_stopped_i,         // axis at rest
  input  wire logic [SPD_W-1:0]       high_speed_i,             // fast setting
  input  wire logic [SPD_W-1:0]       low_speed_i,              // slow setting
  input  wire logic [SPD_W-1:0]       decel_i,                  // decel setting
  output logic                        run_o,                    // move command
  output logic                        dir_neg_o,                // 1 = negative
  output logic      [SPD_W-1:0]       speed_o,                  // speed command
  output logic      [SPD_W-1:0]       decel_o,                  // decel command
  output logic                        busy_o,                   // homing active
  output logic                        homing_done_o,            // home found
  output logic                        alarm_o,                  // homing aborted
  output logic      [POS_W-1:0]       home_position_o           // home reference
);

  // ----------------------------------------------------------------
  // pin synchronisation and edges
  // ----------------------------------------------------------------
  logic [3:0] pins_sync;  // index, pl, nl, hs after two flops
  logic       hs_dly_reg;  // home switch one cycle late
  logic       idx_dly_reg; // index one cycle late

  hsq_pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     ({index_i, positive_limit_switch_i,
                 negative_limit_switch_i, home_switch_i}),
    .sync_o    (pins_sync)
  );

  logic hs;        // home switch level
  logic nl;        // negative limit level
  logic pl;        // positive limit level
  logic idx_rise;  // index pulse leading edge
  logic hs_rise;   // home switch activation
  logic hs_fall;   // home switch deactivation

  assign hs       = pins_sync[0];
  assign nl       = pins_sync[1];
  assign pl       = pins_sync[2];
  assign idx_rise = pins_sync[3] & ~idx_dly_reg;
  assign hs_rise  = hs & ~hs_dly_reg;
  assign hs_fall  = ~hs & hs_dly_reg;

  // delay stages for edge detection
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      hs_dly_reg  <= 1'b0;
      idx_dly_reg <= 1'b0;
    end else begin
      hs_dly_reg  <= hs;
      idx_dly_reg <= pins_sync[3];
    end
  end

  // ----------------------------------------------------------------
  // mode table
  // ----------------------------------------------------------------
  logic [`HSQ_MODE_W-1:0] mode_reg;  // latched mode
  logic mode_ok;                     // start mode is supported
  logic first_neg;                   // first fast run goes negative
  logic first_fall;                  // first run stops on deactivation
  logic rev_fall;                    // reversal run stops on deactivation
  logic slow_neg;                    // slow search goes negative
  logic slow_fall;                   // slow search waits for deactivation

  assign mode_ok = (mode_i >= `HSQ_MODE_11) && (mode_i <= `HSQ_MODE_14);

  // first run depends on requested mode and current switch level
  always_comb begin
    first_neg  = 1'b1;
    first_fall = 1'b0;
    case (mode_i)
      `HSQ_MODE_11, `HSQ_MODE_12: begin
        first_neg  = ~hs;  // active start runs positive
        first_fall = hs;   // inactive start seeks activation
      end
      `HSQ_MODE_13, `HSQ_MODE_14: begin
        first_neg  = 1'b1;  // always negative first
        first_fall = 1'b1;  // stop at deactivation
      end
      default: begin
        first_neg  = 1'b1;
        first_fall = 1'b0;
      end
    endcase
  end

  // reversal run and slow search depend on the latched mode
  always_comb begin
    rev_fall  = 1'b1;
    slow_neg  = 1'b0;
    slow_fall = 1'b1;
    case (mode_reg)
      `HSQ_MODE_11: begin
        rev_fall  = 1'b1;  // stop on deactivation
        slow_neg  = 1'b0;  // slow forward to deactivation
        slow_fall = 1'b1;
      end
      `HSQ_MODE_12: begin
        rev_fall  = 1'b1;  // stop on deactivation
        slow_neg  = 1'b1;  // slow negative to activation
        slow_fall = 1'b0;
      end
      `HSQ_MODE_13: begin
        rev_fall  = 1'b0;  // stop on activation
        slow_neg  = 1'b0;  // slow positive to activation
        slow_fall = 1'b0;
      end
      `HSQ_MODE_14: begin
        rev_fall  = 1'b0;  // stop on activation
        slow_neg  = 1'b1;  // slow negative to deactivation
        slow_fall = 1'b1;
      end
      default: begin
        rev_fall  = 1'b1;
        slow_neg  = 1'b0;
        slow_fall = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  hsq_state_t state_reg;     // current step
  hsq_after_t after_reg;     // step after the current halt
  logic       first_fall_reg; // edge of the first run
  logic       nl_seen_reg;   // negative limit reversal used
  logic       run_reg;       // motion commanded
  logic       dir_neg_reg;   // direction of motion
  logic       fast_reg;      // high speed selected
  logic       moving;        // in a step that commands motion
  logic       edge_hit;      // edge awaited by the current run

  assign moving = (state_reg == HSQ_SEEK_FAST) || (state_reg == HSQ_SEEK_REV) ||
                  (state_reg == HSQ_BACKOFF) || (state_reg == HSQ_SLOW) ||
                  (state_reg == HSQ_INDEX);

  // edge that ends the present run
  always_comb begin
    case (state_reg)
      HSQ_SEEK_FAST: edge_hit = first_fall_reg ? hs_fall : hs_rise;
      HSQ_SEEK_REV:  edge_hit = rev_fall ? hs_fall : hs_rise;
      HSQ_SLOW:      edge_hit = slow_fall ? hs_fall : hs_rise;
      default:       edge_hit = 1'b0;
    endcase
  end

  // step sequencing, limits and direction
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_reg      <= HSQ_IDLE;
      after_reg      <= HSQ_AFT_CHECK;
      mode_reg       <= `HSQ_MODE_11;
      first_fall_reg <= 1'b0;
      nl_seen_reg    <= 1'b0;
      run_reg        <= 1'b0;
      dir_neg_reg    <= 1'b0;
      fast_reg       <= 1'b0;
    end else if (state_reg == HSQ_IDLE) begin
      // accept a start only for the four modes served here
      if (start_i && mode_ok) begin
        mode_reg       <= mode_i;
        first_fall_reg <= first_fall;
        dir_neg_reg    <= first_neg;
        nl_seen_reg    <= 1'b0;
        fast_reg       <= 1'b1;
        run_reg        <= 1'b1;
        state_reg      <= HSQ_SEEK_FAST;
      end
    end else if (moving && pl) begin
      run_reg   <= 1'b0;  // positive limit always aborts
      after_reg <= HSQ_AFT_ABORT;
      state_reg <= HSQ_HALT;
    end else if (moving && dir_neg_reg && nl) begin
      run_reg     <= 1'b0;  // decelerate on the negative limit
      nl_seen_reg <= 1'b1;
      after_reg   <= nl_seen_reg ? HSQ_AFT_ABORT : HSQ_AFT_REV;
      state_reg   <= HSQ_HALT;
    end else begin
      case (state_reg)
        // fast runs stop on their edge
        HSQ_SEEK_FAST, HSQ_SEEK_REV: begin
          if (edge_hit) begin
            run_reg   <= 1'b0;
            after_reg <= HSQ_AFT_CHECK;
            state_reg <= HSQ_HALT;
          end
        end
        // back-off ends once the switch shows the needed level
        HSQ_BACKOFF: begin
          if (hs == slow_fall) begin
            run_reg   <= 1'b0;
            after_reg <= HSQ_AFT_CHECK;
            state_reg <= HSQ_HALT;
          end
        end
        // home edge found, keep going for the index
        HSQ_SLOW: begin
          if (edge_hit) begin
            state_reg <= HSQ_INDEX;
          end
        end
        // nearest index pulse in the slow direction
        HSQ_INDEX: begin
          if (idx_rise) begin
            run_reg   <= 1'b0;
            after_reg <= HSQ_AFT_DONE;
            state_reg <= HSQ_HALT;
          end
        end
        // wait for standstill, then dispatch
        HSQ_HALT: begin
          if (motion_stopped_i) begin
            case (after_reg)
              HSQ_AFT_REV: begin
                dir_neg_reg <= 1'b0;  // run positive at high speed
                fast_reg    <= 1'b1;
                run_reg     <= 1'b1;
                state_reg   <= HSQ_SEEK_REV;
              end
              HSQ_AFT_CHECK: begin
                if (hs != slow_fall) begin
                  dir_neg_reg <= ~dir_neg_reg;  // fast return
                  fast_reg    <= 1'b1;
                  run_reg     <= 1'b1;
                  state_reg   <= HSQ_BACKOFF;
                end else begin
                  dir_neg_reg <= slow_neg;  // slow search
                  fast_reg    <= 1'b0;
                  run_reg     <= 1'b1;
                  state_reg   <= HSQ_SLOW;
                end
              end
              default: begin
                state_reg <= HSQ_IDLE;
              end
            endcase
          end
        end
        default: begin
          state_reg <= HSQ_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status and commands
  // ----------------------------------------------------------------
  logic             done_reg;   // homing completed
  logic             alarm_reg;  // homing aborted
  logic [POS_W-1:0] home_reg;   // captured index position
  logic [SPD_W-1:0] speed_reg;  // speed command
  logic [SPD_W-1:0] decel_reg;  // deceleration command
  logic             busy_reg;   // homing in progress

  // busy leaves idle with an accepted start, ends at the final dispatch
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
    end else if (state_reg == HSQ_IDLE) begin
      busy_reg <= start_i && mode_ok;
    end else if (state_reg == HSQ_HALT && motion_stopped_i &&
                 (after_reg == HSQ_AFT_DONE || after_reg == HSQ_AFT_ABORT)) begin
      busy_reg <= 1'b0;
    end
  end

  // done, alarm and home reference
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      done_reg  <= 1'b0;
      alarm_reg <= 1'b0;
      home_reg  <= '0;
    end else begin
      if (state_reg == HSQ_IDLE && start_i && mode_ok) begin
        done_reg  <= 1'b0;
        alarm_reg <= 1'b0;
      end
      if (state_reg == HSQ_INDEX && idx_rise && !pl &&
          !(dir_neg_reg && nl)) begin
        home_reg <= position_i;  // index position is the reference
      end
      if (state_reg == HSQ_HALT && motion_stopped_i) begin
        if (after_reg == HSQ_AFT_DONE) begin
          done_reg <= 1'b1;  // mark homing done
        end
        if (after_reg == HSQ_AFT_ABORT) begin
          alarm_reg <= 1'b1;  // raise alarm, done stays low
        end
      end
    end
  end

  // speed and deceleration follow the outside settings
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      speed_reg <= '0;
      decel_reg <= '0;
    end else begin
      speed_reg <= fast_reg ? high_speed_i : low_speed_i;
      decel_reg <= decel_i;
    end
  end

  assign run_o           = run_reg;
  assign dir_neg_o       = dir_neg_reg;
  assign speed_o         = speed_reg;
  assign decel_o         = decel_reg;
  assign busy_o          = busy_reg;
  assign homing_done_o   = done_reg;
  assign alarm_o         = alarm_reg;
  assign home_position_o = home_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_halted;
    (state_reg == HSQ_HALT) && !run_reg;
  endsequence

  property p_pl_abort;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      moving && pl |=> s_halted ##0 (after_reg == HSQ_AFT_ABORT);
  endproperty
  a_pl_abort: assert property (p_pl_abort) else $error("positive limit did not abort");

  property p_nl_first;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      moving && !pl && dir_neg_reg && nl && !nl_seen_reg
      |=> s_halted ##0 (after_reg == HSQ_AFT_REV) && nl_seen_reg;
  endproperty
  a_nl_first: assert property (p_nl_first)
    else $error("first negative limit not reversed");

  property p_nl_second;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      moving && dir_neg_reg && nl && nl_seen_reg |=> after_reg == HSQ_AFT_ABORT;
  endproperty
  a_nl_second: assert property (p_nl_second)
    else $error("second negative limit not aborted");

  property p_rev_positive;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      state_reg == HSQ_HALT && after_reg == HSQ_AFT_REV && motion_stopped_i
      |=> state_reg == HSQ_SEEK_REV && run_reg && !dir_neg_reg && fast_reg;
  endproperty
  a_rev_positive: assert property (p_rev_positive)
    else $error("reversal not fast positive");

  property p_mode11_active;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      state_reg == HSQ_IDLE && start_i && mode_i == `HSQ_MODE_11 && hs
      |=> run_reg && !dir_neg_reg && fast_reg && first_fall_reg;
  endproperty
  a_mode11_active: assert property (p_mode11_active) else $error("mode 11 start wrong");

  property p_slow_dir;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      state_reg == HSQ_SLOW |-> run_reg && !fast_reg && dir_neg_reg == slow_neg;
  endproperty
  a_slow_dir: assert property (p_slow_dir) else $error("slow search direction wrong");

  property p_speed;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      fast_reg ##1 1'b1 |-> speed_o == $past(high_speed_i);
  endproperty
  a_speed: assert property (p_speed) else $error("high speed not from setting");

  property p_index_capture;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      state_reg == HSQ_INDEX && idx_rise && !pl && !(dir_neg_reg && nl)
      |=> s_halted ##0 (home_position_o == $past(position_i));
  endproperty
  a_index_capture: assert property (p_index_capture) else $error("index not captured");

  property p_done_clean;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(homing_done_o) |-> !alarm_o && !busy_o;
  endproperty
  a_done_clean: assert property (p_done_clean) else $error("done raised with alarm");

endmodule

// *** hsq_pin_sync.sv ***
// two-stage synchroniser for a group of pin inputs
module hsq_pin_sync
  import hsq_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_sys_i,  // system clock
  input  wire logic             rst_n_i,    // synchronous reset
  input  wire logic [WIDTH-1:0] pin_i,      // raw pin levels
  output logic      [WIDTH-1:0] sync_o      // levels in clock domain
);

  // ----------------------------------------------------------------
  // one two-flop chain per bit
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_reg;  // first stage, read only by second
      logic sync_reg;  // second stage
      // shift the pin through two flops
      always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= pin_i[g];
          sync_reg <= meta_reg;
        end
      end
      assign sync_o[g] = sync_reg;
    end
  endgenerate

endmodule

// *** hsq_pkg.sv ***
// types of the homing sequencer
package hsq_pkg;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HSQ_IDLE,       // waiting for a start
    HSQ_SEEK_FAST,  // first fast search
    HSQ_SEEK_REV,   // fast positive run after limit reversal
    HSQ_BACKOFF,    // fast return to the needed switch level
    HSQ_SLOW,       // slow search for the home edge
    HSQ_INDEX,      // slow run to the next index pulse
    HSQ_HALT        // decelerating, waiting for standstill
  } hsq_state_t;

  // ----------------------------------------------------------------
  // what follows a halt
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HSQ_AFT_CHECK,  // decide back-off or slow search
    HSQ_AFT_REV,    // start the reversal run
    HSQ_AFT_DONE,   // finish with success
    HSQ_AFT_ABORT   // finish with alarm
  } hsq_after_t;

endpackage

// *** testbench.sv ***
// self-checking bench of the homing sequencer against an axis model
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import hsq_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk_sys_i = 1'b0;  // system clock
  logic        rst_n_i   = 1'b0;  // reset, active low
  logic        start_i   = 1'b0;  // start request
  logic [4:0]  mode_i    = 5'h00; // homing mode
  logic [15:0] hi_spd    = 16'h0; // fast setting
  logic [15:0] lo_spd    = 16'h0; // slow setting
  logic [15:0] dc        = 16'h0; // decel setting
  logic        load      = 1'b0;  // axis placement strobe
  logic [31:0] load_pos  = 32'h0; // axis placement
  logic [1:0]  frc       = 2'h0;  // forced limits
  logic        hs, nl, pl, idx, stopped;
  logic [31:0] pos, home_pos;
  logic        run, dir_neg, busy, done, alarm;
  logic [15:0] speed, decel;
  int          n_fail    = 0;     // mismatches
  int          tests_run = 0;     // comparisons
  int          cyc       = 0;     // cycle count for the hang limit
  int          moves[$];          // observed moves: 2*dir_neg + fast
  logic        run_q     = 1'b0;  // run one sample back
  logic        sp_pend   = 1'b0;  // speed due at next sample

  hsq_axis_model axis (
    .clk_sys_i(clk_sys_i), .run_i(run), .dir_neg_i(dir_neg), .load_i(load),
    .load_pos_i(load_pos), .force_i(frc), .home_switch_o(hs),
    .negative_limit_switch_o(nl), .positive_limit_switch_o(pl),
    .index_o(idx), .position_o(pos), .motion_stopped_o(stopped)
  );

  hsq_homing dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .start_i(start_i), .mode_i(mode_i),
    .home_switch_i(hs), .negative_limit_switch_i(nl), .positive_limit_switch_i(pl),
    .index_i(idx), .position_i(pos), .motion_stopped_i(stopped),
    .high_speed_i(hi_spd), .low_speed_i(lo_spd), .decel_i(dc), .run_o(run),
    .dir_neg_o(dir_neg), .speed_o(speed), .decel_o(decel), .busy_o(busy),
    .homing_done_o(done), .alarm_o(alarm), .home_position_o(home_pos)
  );

  // ----------------------------------------------------------------
  // clock and hang limit
  // ----------------------------------------------------------------
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // move monitor: records direction and speed class of each run
  // ----------------------------------------------------------------
  always @(negedge clk_sys_i) begin
    if (sp_pend) begin
      moves.push_back(2 * int'(dir_neg === 1'b1) + int'(speed === hi_spd));
      check("speed_o", 32'h1, 32'(speed === hi_spd || speed === lo_spd));
      check("decel_o", 32'(dc), 32'(decel));
    end
    sp_pend = run === 1'b1 && run_q === 1'b0;
    run_q   = run;
  end

  // ----------------------------------------------------------------
  // one homing run; seq holds expected moves as hex digits, first on
  // the left; frc_at forces a limit once that many moves are seen
  // ----------------------------------------------------------------
  task automatic run_case(input int mode, input int p0, input int n, input int seq,
                          input int exp_home, input int frc_at);
    int q[$];
    int i;
    int w;
    int d;
    for (i = n - 1; i >= 0; i--) begin
      q.push_back((seq >> (4 * i)) & 3);
    end
    moves.delete();
    @(negedge clk_sys_i);
    hi_spd   = {1'b1, 15'($urandom)};
    lo_spd   = {1'b0, 15'($urandom)};
    dc       = 16'($urandom);
    load     = 1'b1;
    load_pos = 32'(p0 + ($urandom % 8));
    @(negedge clk_sys_i);
    load = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    mode_i  = 5'(mode);
    start_i = 1'b1;
    @(negedge clk_sys_i);
    start_i = 1'b0;
    @(negedge clk_sys_i);
    check("busy_o", 32'h1, 32'(busy));
    w = 0;
    while (busy !== 1'b0 && w < 20000) begin
      @(negedge clk_sys_i);
      w++;
      if (frc_at != 0 && moves.size() == frc_at) begin
        frc = (frc_at == 1) ? 2'h2 : 2'h1;
      end
    end
    frc = 2'h0;
    check("busy_o", 32'h0, 32'(busy));
    check("moves", 32'(n), 32'(moves.size()));
    for (i = 0; i < n && i < moves.size(); i++) begin
      check("move", 32'(q[i]), 32'(moves[i]));
    end
    check("homing_done_o", 32'(frc_at == 0), 32'(done));
    check("alarm_o", 32'(frc_at != 0), 32'(alarm));
    if (frc_at == 0) begin
      d = int'(home_pos) - exp_home;
      if (mode == 11 || mode == 13) begin
        check("home_position_o", 32'h1, 32'(d >= 0 && d <= 5));
      end else begin
        check("home_position_o", 32'h1, 32'(d <= 0 && d >= -5));
      end
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(9));
    repeat (8) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    // an unsupported mode is ignored
    mode_i  = 5'h0f;
    start_i = 1'b1;
    @(negedge clk_sys_i);
    start_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    check("busy_o", 32'h0, 32'(busy));
    run_case(11, 120, 3, 'h130, 160, 0);
    run_case(12, 120, 2, 'h12, 144, 0);
    run_case(12, 200, 3, 'h312, 144, 0);
    run_case(12, 40, 3, 'h312, 144, 0);
    run_case(13, 200, 2, 'h30, 112, 0);
    run_case(13, 40, 4, 'h3130, 112, 0);
    run_case(13, 120, 2, 'h30, 112, 0);
    run_case(14, 200, 3, 'h312, 96, 0);
    run_case(14, 40, 3, 'h312, 96, 0);
    run_case(14, 120, 3, 'h312, 96, 0);
    run_case(12, 120, 1, 'h1, 0, 1);
    run_case(13, 40, 3, 'h313, 0, 3);
    summarize();
  end
endmodule
